// ===== mode_ctrl.sv
// Operating mode controller: mode decode, control registers, strobe and gates
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module mode_ctrl
    import mode_ctrl_pkg::*;
#(
    parameter int DATA_W = EXT_DATA_W
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  hw_standby_in,
    input  wire logic                  wdt_reset_in,
    input  wire logic                  mode_pin_hi_in,
    input  wire logic                  mode_pin_lo_in,
    input  wire reg_req_s              reg_req_in,
    output logic [7:0]                 rdata_out,
    input  wire cpu_acc_s              cpu_acc_in,
    output logic                       strobe_n_out,
    output logic                       ext_valid_out,
    output logic [EXT_ADDR_W-1:0]      ext_addr_out,
    output logic                       expanded_out,
    output logic                       advanced_out,
    output logic                       rom_enable_out,
    output logic                       ram_enable_out,
    output logic                       timer_block_out,
    output logic [DATA_W-1:0]          bus_control_out,
    output logic [7:0]                 serial_timer_out
);

    // Pin pattern to mode
    function automatic mode_e decode_mode(input logic hi, input logic lo);
        mode_e m;
        m = MODE_NONE;
        case ({hi, lo})
            2'b01: m = MODE_1; // RQ1
            2'b10: m = MODE_2; // RQ1
            2'b11: m = MODE_3; // RQ1
            default: m = MODE_NONE;
        endcase
        return m;
    endfunction

    // Upper end of the I/O strobe window for a range code
    function automatic logic [15:0] strobe_end(input logic [1:0] sel);
        logic [15:0] e;
        e = STROBE_END3;
        case (sel)
            2'b00: e = STROBE_END0; // RQ19
            2'b01: e = STROBE_END1; // RQ19
            2'b10: e = STROBE_END2; // RQ19
            default: e = STROBE_END3; // RQ19
        endcase
        return e;
    endfunction

    // Window test on the low 16 bits, top byte must be all ones
    function automatic logic in_strobe(input logic [ADDR_W-1:0] a,
                                       input logic [1:0] sel);
        logic hit;
        hit = (a[ADDR_W-1:16] == 8'hff) &&
              (a[15:0] >= STROBE_BASE) &&
              (a[15:0] <= strobe_end(sel));
        return hit;
    endfunction

    // Timer register areas
    function automatic logic in_timer(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = ((a >= TMR_A_LO) && (a <= TMR_A_HI)) ||
              ((a >= TMR_B_LO) && (a <= TMR_B_HI));
        return hit;
    endfunction

    // Register select on the low 16 address bits, shared by the write decoders and the mode read decode
    function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] ofs);
        logic hit;
        hit = (a == ofs);
        return hit;
    endfunction

    // Read image of one register; unmapped offsets read as zero
    function automatic logic [7:0] read_image(input logic [15:0] a,
                                              input logic [7:0]  stc,
                                              input logic [7:0]  sys,
                                              input logic [7:0]  bus,
                                              input logic        expansion_enable,
                                              input logic [1:0]  pins);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            OFS_SERIAL_TIMER: d = stc; // RQ18
            OFS_SYSTEM:       d = sys; // RQ18
            OFS_BUS:          d = bus; // RQ18
            OFS_MODE:         d = {expansion_enable, 5'h00, pins}; // RQ10 RQ11
            default:          d = 8'h00;
        endcase
        return d;
    endfunction

    // Stored register state
    logic [1:0]  pins_r;
    logic        expansion_enable_r;
    logic [7:0]  sys_r;
    logic [7:0]  bus_r;
    logic [7:0]  stc_r;
    logic [1:0]  mode_status_r;
    // Decode and qualifier nets
    mode_e       mode;
    logic        expansion_enable_eff;
    logic        init;
    logic        wr_sys;
    logic        wr_mode;
    logic        wr_bus;
    logic        wr_stc;
    logic        rd_mode;
    logic        expansion_enable_nxt;
    logic [7:0]  sys_nxt;
    logic        ext_live;
    logic        win_hit;

    // System control bit map:
    //   7 host chip-select enable, software keeps it 0
    //   6 strobe select, 0 address strobe, 1 I/O strobe window
    //   5 upper irq mode, read-only in this block
    //   4 lower irq mode, plain storage
    //   3 reset source, 1 external reset, 0 watchdog overflow
    //   2 nmi edge select, plain storage
    //   1 timer access gate, 1 blocks the timer areas
    //   0 ram enable
    // Mode control read image: 7 expansion enable, 6 to 2 zero, 1 to 0 pins

    // Mode pins are steady straps, sampled each cycle
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pins_r <= 2'h0;
        end else begin
            pins_r <= {mode_pin_hi_in, mode_pin_lo_in};
        end
    end

    // The live pins are used for decode; the board holds them steady
    // A strap moved in operation shows at once; the board must not do it
    assign mode = decode_mode(mode_pin_hi_in, mode_pin_lo_in); // RQ1

    // Standby and watchdog both re-initialise the control state
    // The watchdog differs only in clearing the reset source bit
    assign init = hw_standby_in | wdt_reset_in;

    // Register decode on the low 16 address bits
    assign wr_stc  = reg_req_in.wr && reg_hit(reg_req_in.addr, OFS_SERIAL_TIMER); // RQ18
    assign wr_sys  = reg_req_in.wr && reg_hit(reg_req_in.addr, OFS_SYSTEM); // RQ18
    assign wr_mode = reg_req_in.wr && reg_hit(reg_req_in.addr, OFS_MODE); // RQ18
    assign wr_bus  = reg_req_in.wr && reg_hit(reg_req_in.addr, OFS_BUS); // RQ18
    assign rd_mode = reg_req_in.rd && reg_hit(reg_req_in.addr, OFS_MODE);

    // Mode 1 forces expansion regardless of the stored bit
    assign expansion_enable_eff = (mode == MODE_1) ? 1'b1 : expansion_enable_r; // RQ7 RQ8

    // Next expansion bit: software may change it only outside mode 1
    always_comb begin
        expansion_enable_nxt = expansion_enable_r;
        if (wr_mode && (mode != MODE_1)) begin
            expansion_enable_nxt = reg_req_in.wdata[MODE_EXPANSION_ENABLE_BIT]; // RQ4 RQ7
        end
    end

    // Expansion enable: cleared by reset, standby and watchdog, set by software
    // Async reset may not load a pin, so mode 1 is forced on read instead
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            expansion_enable_r <= 1'b0; // RQ4 RQ9
        end else if (init) begin
            expansion_enable_r <= 1'b0; // RQ9
        end else begin
            expansion_enable_r <= expansion_enable_nxt; // RQ4 RQ7
        end
    end

    // Mode status captured at the read; bits 6 to 2 hold nothing
    // Internal copy only; the read data carries the same pin levels
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_status_r <= 2'h0;
        end else if (rd_mode) begin
            mode_status_r <= {mode_pin_hi_in, mode_pin_lo_in}; // RQ10
        end
    end

    // Next system control for a software write; read-only bits keep their value
    always_comb begin
        sys_nxt = sys_r;
        if (wr_sys) begin
            sys_nxt = (reg_req_in.wdata & SYS_WR_MASK) | (sys_r & ~SYS_WR_MASK); // RQ20
        end
    end

    // System control: software bits, read-only bits kept on writes
    // Standby wins over watchdog, and both win over a write in one cycle
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sys_r <= RST_SYSTEM; // RQ12 RQ15 RQ17
        end else if (hw_standby_in) begin
            sys_r <= RST_SYSTEM; // RQ12
        end else if (wdt_reset_in) begin
            sys_r <= RST_SYSTEM;
            sys_r[SYS_RST_SRC_BIT] <= 1'b0; // RQ15
        end else begin
            sys_r <= sys_nxt; // RQ20
        end
    end

    // Bus control and serial/timer control are plain read/write
    // Unused serial/timer bits must be kept 0 by software; nothing enforces it
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bus_r <= RST_BUS;
            stc_r <= RST_SERIAL_TIMER;
        end else if (init) begin
            bus_r <= RST_BUS;
            stc_r <= RST_SERIAL_TIMER;
        end else begin
            if (wr_bus) begin
                bus_r <= reg_req_in.wdata;
            end
            if (wr_stc) begin
                stc_r <= reg_req_in.wdata;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    // Unmapped addresses and idle cycles return zero
    // Zero between reads, so a late sample cannot pass for fresh data
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else if (reg_req_in.rd) begin
            rdata_out <= read_image(reg_req_in.addr, stc_r, sys_r, bus_r, expansion_enable_eff,
                                    {mode_pin_hi_in, mode_pin_lo_in}); // RQ10 RQ18
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // One qualifier and one window hit feed both external pin paths
    assign ext_live = cpu_acc_in.ext && expansion_enable_eff; // RQ8
    assign win_hit  = in_strobe(cpu_acc_in.addr, bus_r[1:0]); // RQ19

    // Strobe pin: address strobe on any external access, or the I/O window
    // Held high outside expanded operation, the pin has no other user here
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strobe_n_out <= 1'b1;
        end else if (ext_live) begin // RQ8
            if (!sys_r[SYS_STROBE_BIT]) begin
                strobe_n_out <= 1'b0; // RQ14
            end else begin
                strobe_n_out <= !win_hit; // RQ14 RQ19
            end
        end else begin
            strobe_n_out <= 1'b1;
        end
    end

    // External address: only 16 pins, so advanced mode is trusted in the window
    // Address pins follow every cycle; the valid flag says when they count
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_addr_out  <= '0;
            ext_valid_out <= 1'b0;
        end else begin
            ext_addr_out <= cpu_acc_in.addr[EXT_ADDR_W-1:0]; // RQ5 RQ6
            if (!ext_live) begin
                ext_valid_out <= 1'b0; // RQ8
            end else if (mode == MODE_2) begin
                ext_valid_out <= sys_r[SYS_STROBE_BIT] && win_hit; // RQ5
            end else begin
                ext_valid_out <= 1'b1;
            end
        end
    end

    // Mode derived status, gates and register images
    // All of these trail their source by one cycle, like the pin paths
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            expanded_out     <= 1'b0;
            advanced_out     <= 1'b0;
            rom_enable_out   <= 1'b0;
            ram_enable_out   <= 1'b1;
            timer_block_out  <= 1'b0;
            bus_control_out  <= RST_BUS;
            serial_timer_out <= RST_SERIAL_TIMER;
        end else begin
            expanded_out     <= expansion_enable_eff; // RQ8
            advanced_out     <= (mode == MODE_2); // RQ1 RQ6
            rom_enable_out   <= (mode == MODE_2) || (mode == MODE_3); // RQ1
            ram_enable_out   <= sys_r[SYS_RAM_BIT]; // RQ17
            timer_block_out  <= sys_r[SYS_TIMER_BIT] &&
                                in_timer(cpu_acc_in.addr); // RQ16
            bus_control_out  <= bus_r;
            serial_timer_out <= stc_r;
        end
    end

endmodule

// ===== mode_ctrl_pkg.sv
// Constants and types shared by the operating mode controller
// How it works
// RQ1 - Mode pins 01, 10, 11 select mode 1, 2, 3 with fixed CPU and ROM setup.
// RQ2 - Board straps only modes 1 to 3; pattern 00 is unusable.
// RQ3 - Board keeps mode pin levels constant while the device operates.
// RQ4 - Modes 2 and 3 start single-chip; expansion only once software sets it.
// RQ5 - External bus is 8 bits with 16 address outputs; advanced needs strobe area.
// RQ6 - Address space is limited to 16 Mbytes, 24 address bits.
// RQ7 - Mode 1 expansion bit reads 1, ignores writes; modes 2, 3 reset 0, read/write.
// RQ8 - Expansion bit 0 means single-chip, 1 means expanded operation.
// RQ9 - Reset and hardware standby set the expansion bit from the mode pins.
// RQ10 - Mode status bits 1:0 are read-only, pin levels latched at register read.
// RQ11 - Mode register bits 6 to 2 ignore writes and read as zero.
// RQ12 - System control loads 0x09 on reset and standby, kept in software standby.
// RQ13 - Software keeps host chip-select enable at 0; no host interface exists.
// RQ14 - Strobe select 0 gives address strobe on any access, 1 an I/O strobe range.
// RQ15 - Reset source bit is read-only: 1 after external reset, 0 after watchdog.
// RQ16 - Timer access gate 0 permits, 1 blocks the two timer register areas.
// RQ17 - RAM enable: 0 disables, 1 enables; resets to 1, kept in software standby.
// RQ18 - Registers sit at 0xffc3, 0xffc4, 0xffc5, 0xffc6 of the low 16 address bits.
// RQ19 - Strobe range field 00..11 ends the range at f03f, f0ff, f3ff, fe4f.
// RQ20 - Writes leave the read-only reset source and upper irq mode bits unchanged.
package mode_ctrl_pkg;
    localparam logic [15:0] OFS_SERIAL_TIMER = 16'hffc3;
    localparam logic [15:0] OFS_SYSTEM       = 16'hffc4;
    localparam logic [15:0] OFS_MODE         = 16'hffc5;
    localparam logic [15:0] OFS_BUS          = 16'hffc6;
    localparam logic [7:0]  RST_SERIAL_TIMER = 8'h00;
    localparam logic [7:0]  RST_SYSTEM       = 8'h09;
    localparam logic [7:0]  RST_BUS          = 8'hd7;
    // Field positions
    localparam int MODE_EXPANSION_ENABLE_BIT   = 7;
    localparam int SYS_HOST_CS_BIT = 7;
    localparam int SYS_STROBE_BIT  = 6;
    localparam int SYS_IRQ_HI_BIT  = 5;
    localparam int SYS_RST_SRC_BIT = 3;
    localparam int SYS_TIMER_BIT   = 1;
    localparam int SYS_RAM_BIT     = 0;
    // System control bits that software may change
    localparam logic [7:0]  SYS_WR_MASK      = 8'hd7;
    // I/O strobe window, low 16 address bits
    localparam logic [15:0] STROBE_BASE      = 16'hf000;
    localparam logic [15:0] STROBE_END0      = 16'hf03f;
    localparam logic [15:0] STROBE_END1      = 16'hf0ff;
    localparam logic [15:0] STROBE_END2      = 16'hf3ff;
    localparam logic [15:0] STROBE_END3      = 16'hfe4f;
    // Timer register areas, full 24-bit addresses
    localparam logic [23:0] TMR_A_LO         = 24'hfffff0;
    localparam logic [23:0] TMR_A_HI         = 24'hfffff7;
    localparam logic [23:0] TMR_B_LO         = 24'hfffffc;
    localparam logic [23:0] TMR_B_HI         = 24'hffffff;
    localparam int ADDR_W     = 24;
    localparam int EXT_ADDR_W = 16;
    localparam int EXT_DATA_W = 8;

    typedef enum logic [1:0] {MODE_NONE, MODE_1, MODE_2, MODE_3} mode_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              ext;
    } cpu_acc_s;
endpackage

// ===== mode_ctrl_props.sv
// Port-level checker for the operating mode controller
`timescale 1ns/1ps
module mode_ctrl_props
    import mode_ctrl_pkg::*;
#(
    parameter int DATA_W = EXT_DATA_W
) (
    input wire logic                  clk_sys_in,
    input wire logic                  rst_b_in,
    input wire logic                  hw_standby_in,
    input wire logic                  wdt_reset_in,
    input wire logic                  mode_pin_hi_in,
    input wire logic                  mode_pin_lo_in,
    input wire reg_req_s              reg_req_in,
    input wire logic [7:0]            rdata_out,
    input wire cpu_acc_s              cpu_acc_in,
    input wire logic                  strobe_n_out,
    input wire logic                  ext_valid_out,
    input wire logic [EXT_ADDR_W-1:0] ext_addr_out,
    input wire logic                  expanded_out,
    input wire logic                  advanced_out,
    input wire logic                  rom_enable_out,
    input wire logic                  ram_enable_out,
    input wire logic                  timer_block_out,
    input wire logic [DATA_W-1:0]     bus_control_out,
    input wire logic [7:0]            serial_timer_out
);
    logic live_r;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in || !live_r);

    // Outputs leave reset one edge after release; checks start from there
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            live_r <= 1'b0;
        end else begin
            live_r <= 1'b1;
        end
    end

    // Reads outside the four mapped offsets must come back empty
    unmapped_read_a: assert property (reg_req_in.rd && !(reg_req_in.addr inside
        {[OFS_SERIAL_TIMER:OFS_BUS]}) |=> rdata_out == 8'h00)
        else $error("unmapped read returned data");
    mode_status_a: assert property (reg_req_in.rd && reg_req_in.addr == OFS_MODE |=>
        rdata_out[6:0] == {5'h00, $past(mode_pin_hi_in), $past(mode_pin_lo_in)})
        else $error("mode status bits wrong");
    mode1_expand_a: assert property (!mode_pin_hi_in && mode_pin_lo_in |=> expanded_out)
        else $error("mode 1 not expanded");
    mode_decode_a: assert property (1'b1 |=> advanced_out == ($past(mode_pin_hi_in) &&
        !$past(mode_pin_lo_in)) && rom_enable_out == $past(mode_pin_hi_in))
        else $error("mode decode wrong");
    no_access_a: assert property (!cpu_acc_in.ext |=> strobe_n_out && !ext_valid_out)
        else $error("strobe without external access");
    ext_addr_a: assert property (cpu_acc_in.ext |=>
        ext_addr_out == $past(cpu_acc_in.addr[15:0]))
        else $error("external address mismatch");
    timer_area_a: assert property (!(cpu_acc_in.addr inside {[TMR_A_LO:TMR_A_HI],
        [TMR_B_LO:TMR_B_HI]}) |=> !timer_block_out)
        else $error("timer block outside timer areas");
    standby_init_a: assert property (hw_standby_in |-> ##2 (bus_control_out == RST_BUS &&
        serial_timer_out == RST_SERIAL_TIMER && ram_enable_out))
        else $error("standby did not initialise registers");
    bus_hold_a: assert property ($changed(bus_control_out) |-> ($past(reg_req_in.wr, 2) &&
        $past(reg_req_in.addr, 2) == OFS_BUS) || $past(hw_standby_in, 2) ||
        $past(wdt_reset_in, 2))
        else $error("bus control changed without write");
    mode1_valid_a: assert property (cpu_acc_in.ext && !mode_pin_hi_in && mode_pin_lo_in
        |=> ext_valid_out)
        else $error("mode 1 access not valid");
endmodule

bind mode_ctrl mode_ctrl_props #(.DATA_W(DATA_W)) u_props (.clk_sys_in, .rst_b_in,
    .hw_standby_in, .wdt_reset_in, .mode_pin_hi_in, .mode_pin_lo_in, .reg_req_in,
    .rdata_out, .cpu_acc_in, .strobe_n_out, .ext_valid_out, .ext_addr_out, .expanded_out,
    .advanced_out, .rom_enable_out, .ram_enable_out, .timer_block_out, .bus_control_out,
    .serial_timer_out);

// ===== mode_strap_model.sv
// Board strap model driving the two mode pins
`timescale 1ns/1ps
module mode_strap_model (
    input  wire logic       rst_b_in,
    input  wire logic [1:0] mode_sel_in,
    output logic            mode_pin_hi_out,
    output logic            mode_pin_lo_out
);
    // Straps move only while reset holds the part; pattern 00 is never offered
    always_latch begin
        if (!rst_b_in) begin
            {mode_pin_hi_out, mode_pin_lo_out} <= (mode_sel_in == 2'h0) ? 2'h3 : mode_sel_in;
        end
    end
endmodule

// ===== testbench.sv
// Register, strobe and reset sequence test of the mode controller
`timescale 1ns/1ps
module testbench;
    import mode_ctrl_pkg::*;
    logic        clk_sys_in, rst_b_in, hw_standby_in, wdt_reset_in, pin_hi, pin_lo;
    logic        strobe_n, ext_valid, expanded, advanced, rom_en, ram_en, timer_block;
    logic [1:0]  mode_sel;
    logic [7:0]  rdata, bus_ctl, ser_tmr;
    logic [15:0] ext_addr;
    logic [15:0] ends [4] = '{STROBE_END0, STROBE_END1, STROBE_END2, STROBE_END3};
    reg_req_s    req;
    cpu_acc_s    cpu;
    int          bad_count = 0;
    int          cmp_count = 0;

    mode_strap_model strap (.rst_b_in(rst_b_in), .mode_sel_in(mode_sel),
        .mode_pin_hi_out(pin_hi), .mode_pin_lo_out(pin_lo));
    mode_ctrl dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hw_standby_in(hw_standby_in),
        .wdt_reset_in(wdt_reset_in), .mode_pin_hi_in(pin_hi), .mode_pin_lo_in(pin_lo),
        .reg_req_in(req), .rdata_out(rdata), .cpu_acc_in(cpu), .strobe_n_out(strobe_n),
        .ext_valid_out(ext_valid), .ext_addr_out(ext_addr), .expanded_out(expanded),
        .advanced_out(advanced), .rom_enable_out(rom_en), .ram_enable_out(ram_en),
        .timer_block_out(timer_block), .bus_control_out(bus_ctl), .serial_timer_out(ser_tmr));

    // Free-running 250 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Straps change only inside a fresh reset of eight cycles
    task automatic restart(input logic [1:0] m);
        mode_sel <= m;
        rst_b_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        req <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        req <= '0;
        #1 chk("rdata", 16'(rdata), 16'(exp));
    endtask

    task automatic acc(input logic [23:0] a, input logic e, input logic s, input logic t);
        @(posedge clk_sys_in);
        cpu <= '{addr: a, ext: e};
        @(posedge clk_sys_in);
        #1 chk("strobe_n", 16'(strobe_n), 16'(s));
        chk("timer_block", 16'(timer_block), 16'(t));
    endtask

    // A hung run is cut short and counted
    initial begin
        #200000;
        bad_count++;
        close_out;
    end

    initial begin
        rst_b_in = 1'b0;
        hw_standby_in = 1'b0;
        wdt_reset_in = 1'b0;
        req = '0;
        cpu = '0;
        mode_sel = 2'h1;
        for (int m = 1; m < 4; m++) begin
            restart(2'(m));
            rd(OFS_MODE, {m == 1, 5'h00, 2'(m)});
            chk("flags", 16'({expanded, advanced, rom_en}), 16'({m == 1, m == 2, m != 1}));
            rd(OFS_SYSTEM, RST_SYSTEM);
            rd(OFS_BUS, RST_BUS);
            rd(OFS_SERIAL_TIMER, RST_SERIAL_TIMER);
            acc(24'h001000, 1'b1, m != 1, 1'b0);
            wr(OFS_MODE, 8'hff);
            rd(OFS_MODE, {1'b1, 5'h00, 2'(m)});
            chk("expanded", 16'(expanded), 16'h0001);
            acc(24'hfff000, 1'b1, 1'b0, 1'b0);
            chk("ext_valid", 16'(ext_valid), 16'(m != 2));
            chk("ext_addr", ext_addr, 16'hf000);
            wr(OFS_MODE, 8'h00);
            rd(OFS_MODE, {m == 1, 5'h00, 2'(m)});
        end
        wr(OFS_SYSTEM, 8'h7f);
        rd(OFS_SYSTEM, 8'h5f);
        wr(OFS_MODE, 8'h80);
        // Each strobe range: last address low, first address past it high
        for (int r = 0; r < 4; r++) begin
            wr(OFS_BUS, 8'(r));
            acc({8'hff, ends[r]}, 1'b1, 1'b0, 1'b0);
            chk("bus_control", 16'(bus_ctl), 16'(r));
            acc({8'hff, ends[r] + 16'h0001}, 1'b1, 1'b1, 1'b0);
        end
        acc(24'hffefff, 1'b1, 1'b1, 1'b0);
        acc(24'hfffff0, 1'b0, 1'b1, 1'b1);
        acc(24'hfffffc, 1'b0, 1'b1, 1'b1);
        acc(24'hfffff8, 1'b0, 1'b1, 1'b0);
        wr(OFS_SYSTEM, 8'h00);
        acc(24'hfffff0, 1'b0, 1'b1, 1'b0);
        acc(24'h001234, 1'b1, 1'b0, 1'b0);
        chk("ram_enable", 16'(ram_en), 16'h0000);
        rd(16'hffc7, 8'h00);
        wr(OFS_SERIAL_TIMER, 8'h5a);
        @(posedge clk_sys_in);
        #1 chk("serial_timer", 16'(ser_tmr), 16'h005a);
        @(posedge clk_sys_in);
        wdt_reset_in <= 1'b1;
        @(posedge clk_sys_in);
        wdt_reset_in <= 1'b0;
        rd(OFS_SYSTEM, 8'h01);
        rd(OFS_MODE, 8'h03);
        @(posedge clk_sys_in);
        hw_standby_in <= 1'b1;
        @(posedge clk_sys_in);
        hw_standby_in <= 1'b0;
        rd(OFS_SYSTEM, RST_SYSTEM);
        chk("ram_enable", 16'(ram_en), 16'h0001);
        close_out;
    end
endmodule
